// ===== sync_control.sv
// fifo and divider synchronisation core with its register slave
`timescale 1ns/10ps
module sync_control (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic output_strobe_i,
  input wire logic sync_i,
  input wire logic frame_i,
  input wire logic [15:0] sample_i,
  input wire logic sample_valid_i,
  output logic [15:0] positive_share_o,
  output logic [15:0] negative_share_o,
  output logic share_valid_o,
  output logic alarm_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0] main_config_register;   // divider sync, offset, ratio
  logic [31:0] sync_select_register;   // source and mode select
  logic [31:0] pll_control_register;   // feedback divider control
  sync_ctrl_pkg::alarm_t alarm_status_register;  // sticky events
  logic [4:0] irq_en_reg;              // interrupt enable, same layout
  logic [31:0] main_next, sel_next, pll_next;
  sync_ctrl_pkg::alarm_t status_next;
  logic [4:0] irq_en_next;
  logic [4:0] clear_bits; // write-one-to-clear pattern
  logic dp_valid_reg, dp_write_reg; // bus data phase pending
  logic [31:0] dp_addr_reg, hrdata_reg;
  logic dp_valid_next, dp_write_next;
  logic [31:0] dp_addr_next, hrdata_next;
  logic ap_take; // address phase accepted
  sync_ctrl_pkg::cfg_t cfg; // decoded fields
  sync_ctrl_pkg::ptr_state_t ptr_state_reg, ptr_state_next;
  logic [15:0] fifo_mem [sync_ctrl_pkg::FIFO_DEPTH];
  logic [3:0] wr_ptr_reg, rd_ptr_reg, wr_ptr_next, rd_ptr_next;
  logic [3:0] level; // occupied slots
  logic [3:0] rd_origin; // read pointer after a reset
  logic [3:0] fb_cnt_reg, fb_cnt_next; // pll feedback divider
  logic [1:0] cd_cnt_reg, cd_cnt_next; // conversion clock divider
  logic [15:0] pos_reg, neg_reg, pos_next, neg_next;
  logic share_valid_reg, share_valid_next, mem_we;
  sync_ctrl_pkg::alarm_t events;
  logic strobe_rise, sync_rise, frame_level, frame_rise, handoff_rise;
  logic int_strobe; // internal strobe from the pll
  logic strobe_evt; // strobe in use
  logic div_src; // divider sync source event
  logic read_tick; // fifo output clock tick
  logic wr_rst, rd_rst, running;

  // true when a bus address selects the given register
  function automatic logic hits(input logic [31:0] a, input logic [31:0] o);
    hits = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input samplers on the conversion clock
  edge_sampler u_strobe (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .level_i(output_strobe_i), .level_o(), .rise_o(strobe_rise)
  );
  edge_sampler u_sync (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .level_i(sync_i), .level_o(), .rise_o(sync_rise)
  );
  edge_sampler u_frame (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .level_i(frame_i), .level_o(frame_level), .rise_o(frame_rise)
  );
  // write reset resampled into the fifo output side; arrives two cycles late
  edge_sampler u_handoff (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .level_i(frame_level), .level_o(), .rise_o(handoff_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode and event sources
  always_comb begin
    cfg.divsync_en = main_config_register[sync_ctrl_pkg::MAIN_DIVSYNC_EN_BIT];
    cfg.offset = main_config_register[sync_ctrl_pkg::MAIN_OFFSET_LSB +: 3];
    cfg.div_m1 = main_config_register[sync_ctrl_pkg::MAIN_DIVM1_LSB +: 2];
    cfg.divsrc_sync = sync_select_register[sync_ctrl_pkg::SEL_DIVSRC_BIT];
    cfg.dual_mode = sync_select_register[sync_ctrl_pkg::SEL_DUAL_BIT];
    cfg.pll_en = sync_select_register[sync_ctrl_pkg::SEL_PLL_BIT];
    cfg.fbrst_en = pll_control_register[sync_ctrl_pkg::PLL_FBRST_EN_BIT];
    cfg.fb_m1 = pll_control_register[sync_ctrl_pkg::PLL_FBM1_LSB +: 4];
  end

  assign int_strobe = (fb_cnt_reg == cfg.fb_m1);
  // pll mode needs no external strobe; the pin is then ignored
  assign strobe_evt = cfg.pll_en ? int_strobe : strobe_rise;
  assign div_src = cfg.divsrc_sync ? sync_rise : strobe_evt;
  assign read_tick = (cd_cnt_reg == cfg.div_m1);
  assign wr_rst = frame_rise;
  // dual: strobe aligns reads; single: only the handed-off write reset
  assign rd_rst = cfg.dual_mode ? strobe_evt : handoff_rise;
  assign running = (ptr_state_reg == sync_ctrl_pkg::PTR_RUN);
  assign level = wr_ptr_reg - rd_ptr_reg;
  // read pointer trails a reset write pointer by the offset
  assign rd_origin = 4'h0 - {1'b0, cfg.offset};

  ////////////////////////////////////////////////////////////////////////////
  // datapath: dividers, pointers, shares, events
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    fb_cnt_next = fb_cnt_reg + 4'h1;
    cd_cnt_next = cd_cnt_reg + 2'h1;
    ptr_state_next = ptr_state_reg;
    pos_next = pos_reg;
    neg_next = neg_reg;
    share_valid_next = 1'b0;
    mem_we = 1'b0;
    events = '0;
    // feedback divider; sync is judged only against this clock
    if (cfg.fbrst_en && sync_rise) begin
      fb_cnt_next = 4'h0;
      events.fb_reset = 1'b1;
    end else if (int_strobe) begin
      fb_cnt_next = 4'h0;
    end
    // divider alignment, held while software leaves sync enabled
    if (cfg.divsync_en && div_src) begin
      cd_cnt_next = 2'h0;
      events.div_sync = 1'b1;
    end else if (read_tick) begin
      cd_cnt_next = 2'h0;
    end
    // write side; once running, a full fifo drops the word rather than overwrite
    if (wr_rst) begin
      wr_ptr_next = 4'h0;
    end else if (sample_valid_i) begin
      if (running && level == sync_ctrl_pkg::LEVEL_FULL) begin
        events.collision = 1'b1;
      end else begin
        mem_we = 1'b1;
        wr_ptr_next = wr_ptr_reg + 4'h1;
      end
    end
    // read side; a reset wins over a read in the same cycle
    if (rd_rst) begin
      rd_ptr_next = rd_origin;
    end else if (running && read_tick) begin
      if (level == sync_ctrl_pkg::LEVEL_EMPTY) begin
        events.collision = 1'b1;
      end else begin
        rd_ptr_next = rd_ptr_reg + 4'h1;
        pos_next = fifo_mem[rd_ptr_reg[2:0]];
        neg_next = sync_ctrl_pkg::CODE_MAX - fifo_mem[rd_ptr_reg[2:0]];
        share_valid_next = 1'b1;
        events.one_away = (level <= sync_ctrl_pkg::ONE_AWAY_LO) ||
                          (level >= sync_ctrl_pkg::ONE_AWAY_HI);
        events.two_away = (level <= sync_ctrl_pkg::TWO_AWAY_LO) ||
                          (level >= sync_ctrl_pkg::TWO_AWAY_HI);
      end
    end
    // bring-up: reads start only once both pointers were reset
    case (ptr_state_reg)
      sync_ctrl_pkg::PTR_WAIT_WR: begin
        if (wr_rst) begin
          ptr_state_next = sync_ctrl_pkg::PTR_WAIT_RD;
        end
      end
      sync_ctrl_pkg::PTR_WAIT_RD: begin
        if (rd_rst) begin
          ptr_state_next = sync_ctrl_pkg::PTR_RUN;
        end
      end
      default: begin
        ptr_state_next = sync_ctrl_pkg::PTR_RUN;
      end
    endcase
  end

  // datapath registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= 4'h0;
      rd_ptr_reg <= 4'h0;
      fb_cnt_reg <= 4'h0;
      cd_cnt_reg <= 2'h0;
      ptr_state_reg <= sync_ctrl_pkg::PTR_WAIT_WR;
      pos_reg <= 16'h0000;
      neg_reg <= 16'h0000;
      share_valid_reg <= 1'b0;
    end else if (ce_i) begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      fb_cnt_reg <= fb_cnt_next;
      cd_cnt_reg <= cd_cnt_next;
      ptr_state_reg <= ptr_state_next;
      pos_reg <= pos_next;
      neg_reg <= neg_next;
      share_valid_reg <= share_valid_next;
    end
  end

  // fifo storage, cleared: reads may run ahead of the first writes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < int'(sync_ctrl_pkg::FIFO_DEPTH); i++) begin
        fifo_mem[i] <= 16'h0000;
      end
    end else if (ce_i && mem_we) begin
      fifo_mem[wr_ptr_reg[2:0]] <= sample_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave and register file; zero wait states while enabled
  assign ap_take = ce_i && hsel_i && hready_i && htrans_i[1];

  always_comb begin
    main_next = main_config_register;
    sel_next = sync_select_register;
    pll_next = pll_control_register;
    irq_en_next = irq_en_reg;
    clear_bits = 5'h00;
    dp_valid_next = ap_take;
    dp_write_next = ap_take && hwrite_i;
    dp_addr_next = ap_take ? haddr_i : dp_addr_reg;
    hrdata_next = hrdata_reg;
    // read data is fetched in the address phase; unmapped reads as zero
    if (ap_take && !hwrite_i) begin
      if (hits(haddr_i, sync_ctrl_pkg::OFS_MAIN)) begin
        hrdata_next = main_config_register;
      end else if (hits(haddr_i, sync_ctrl_pkg::OFS_SYNC_SEL)) begin
        hrdata_next = sync_select_register;
      end else if (hits(haddr_i, sync_ctrl_pkg::OFS_PLL)) begin
        hrdata_next = pll_control_register;
      end else if (hits(haddr_i, sync_ctrl_pkg::OFS_ALARM)) begin
        hrdata_next = {27'h0, alarm_status_register};
      end else if (hits(haddr_i, sync_ctrl_pkg::OFS_ENABLE)) begin
        hrdata_next = {27'h0, irq_en_reg};
      end else if (hits(haddr_i, sync_ctrl_pkg::OFS_STATE)) begin
        hrdata_next = {17'h0, running, fb_cnt_reg, cd_cnt_reg,
                       rd_ptr_reg, wr_ptr_reg};
      end else begin
        hrdata_next = 32'h0000_0000;
      end
    end
    // writes land in the data phase; unmapped writes are dropped
    if (dp_valid_reg && dp_write_reg) begin
      if (hits(dp_addr_reg, sync_ctrl_pkg::OFS_MAIN)) begin
        main_next = hwdata_i & sync_ctrl_pkg::MAIN_MASK;
      end else if (hits(dp_addr_reg, sync_ctrl_pkg::OFS_SYNC_SEL)) begin
        sel_next = hwdata_i & sync_ctrl_pkg::SEL_MASK;
      end else if (hits(dp_addr_reg, sync_ctrl_pkg::OFS_PLL)) begin
        pll_next = hwdata_i & sync_ctrl_pkg::PLL_MASK;
      end else if (hits(dp_addr_reg, sync_ctrl_pkg::OFS_CLEAR)) begin
        clear_bits = hwdata_i[4:0];
      end else if (hits(dp_addr_reg, sync_ctrl_pkg::OFS_ENABLE)) begin
        irq_en_next = hwdata_i[4:0];
      end
    end
    // a new event beats a clear in the same cycle
    status_next = (alarm_status_register & ~clear_bits) | events;
  end

  // register file flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_config_register <= sync_ctrl_pkg::MAIN_RST;
      sync_select_register <= sync_ctrl_pkg::SEL_RST;
      pll_control_register <= sync_ctrl_pkg::PLL_RST;
      alarm_status_register <= '0;
      irq_en_reg <= 5'h00;
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 32'h0000_0000;
      hrdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      main_config_register <= main_next;
      sync_select_register <= sel_next;
      pll_control_register <= pll_next;
      alarm_status_register <= status_next;
      irq_en_reg <= irq_en_next;
      dp_valid_reg <= dp_valid_next;
      dp_write_reg <= dp_write_next;
      dp_addr_reg <= dp_addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // outputs; a low clock enable stalls the bus instead of losing a transfer
  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = ce_i;
  assign hresp_o = 1'b0;
  assign positive_share_o = pos_reg;
  assign negative_share_o = neg_reg;
  assign share_valid_o = share_valid_reg;
  assign alarm_o = alarm_status_register.collision |
                   alarm_status_register.one_away |
                   alarm_status_register.two_away;
  assign irq_o = |(alarm_status_register & irq_en_reg);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence frame_seen_s;
    !cfg.dual_mode && $rose(frame_i);
  endsequence
  sequence held_single_s;
    (ce_i && !cfg.dual_mode)[*5];
  endsequence

  share_inverse_a: assert property (share_valid_o |->
    negative_share_o == sync_ctrl_pkg::CODE_MAX - positive_share_o)
    else $error("negative share not complement of positive share");
  fb_reset_a: assert property (ce_i && cfg.fbrst_en && sync_rise
    |=> fb_cnt_reg == 4'h0 && alarm_status_register.fb_reset)
    else $error("feedback divider not reset by sync rise");
  internal_strobe_a: assert property (ce_i && cfg.pll_en
    && cfg.dual_mode && int_strobe |=> rd_ptr_reg == $past(rd_origin))
    else $error("internal strobe did not align read pointer");
  ext_strobe_a: assert property (ce_i && !cfg.pll_en
    && cfg.dual_mode && strobe_rise |=> rd_ptr_reg == $past(rd_origin))
    else $error("output strobe did not align read pointer");
  single_handoff_a: assert property (frame_seen_s ##0 held_single_s
    |=> rd_ptr_reg == rd_origin)
    else $error("write reset not handed to read pointer");
  empty_read_a: assert property (ce_i && running && read_tick
    && !rd_rst && level == sync_ctrl_pkg::LEVEL_EMPTY
    |=> alarm_status_register.collision ##0 alarm_o)
    else $error("empty read raised no collision alarm");
  sticky_alarm_a: assert property (alarm_status_register.collision
    && !(dp_valid_reg && dp_write_reg) |=> alarm_status_register.collision)
    else $error("collision alarm dropped without a clear");
  div_sync_a: assert property (ce_i && cfg.divsync_en && div_src
    |=> cd_cnt_reg == 2'h0 ##1 cd_cnt_reg == (cfg.div_m1 == 2'h0 ? 2'h0
        : 2'h1) || !ce_i)
    else $error("clock divider not aligned by its sync source");

endmodule

// ===== sync_ctrl_pkg.sv
// shared constants and types for the multi-converter sync control block
package sync_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sample path and fifo geometry
  localparam int unsigned DATA_W = 16;      // one input sample word
  localparam int unsigned FIFO_DEPTH = 8;   // input fifo slots
  localparam int unsigned PTR_W = 4;        // one wrap bit above the index
  localparam logic [15:0] CODE_MAX = 16'hFFFF;  // full-scale code, 65535
  localparam logic [3:0] LEVEL_FULL = 4'h8;     // every slot occupied
  localparam logic [3:0] LEVEL_EMPTY = 4'h0;
  localparam logic [3:0] ONE_AWAY_LO = 4'h1;    // one slot from collision
  localparam logic [3:0] ONE_AWAY_HI = 4'h7;
  localparam logic [3:0] TWO_AWAY_LO = 4'h2;    // two slots from collision
  localparam logic [3:0] TWO_AWAY_HI = 4'h6;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [31:0] OFS_MAIN = 32'h0000_0000;    // main config
  localparam logic [31:0] OFS_SYNC_SEL = 32'h0000_0004;
  localparam logic [31:0] OFS_PLL = 32'h0000_0008;
  localparam logic [31:0] OFS_ALARM = 32'h0000_000C;   // sticky, read-only
  localparam logic [31:0] OFS_CLEAR = 32'h0000_0010;   // write-only
  localparam logic [31:0] OFS_ENABLE = 32'h0000_0014;  // interrupt enable
  localparam logic [31:0] OFS_STATE = 32'h0000_0018;   // live pointers

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned MAIN_DIVSYNC_EN_BIT = 0;  // divider sync enable
  localparam int unsigned MAIN_OFFSET_LSB = 4;      // 3-bit read offset
  localparam int unsigned MAIN_DIVM1_LSB = 8;       // 2-bit ratio minus one
  localparam int unsigned SEL_DIVSRC_BIT = 0;       // 0 strobe, 1 sync line
  localparam int unsigned SEL_DUAL_BIT = 1;         // dual sync sources
  localparam int unsigned SEL_PLL_BIT = 2;          // internal pll in use
  localparam int unsigned PLL_FBRST_EN_BIT = 0;     // feedback reset enable
  localparam int unsigned PLL_FBM1_LSB = 8;         // 4-bit ratio minus one

  ////////////////////////////////////////////////////////////////////////////
  // reset values and writable masks
  localparam logic [31:0] MAIN_RST = 32'h0000_0141;
  localparam logic [31:0] MAIN_MASK = 32'h0000_0371;
  localparam logic [31:0] SEL_RST = 32'h0000_0002;
  localparam logic [31:0] SEL_MASK = 32'h0000_0007;
  localparam logic [31:0] PLL_RST = 32'h0000_0F00;
  localparam logic [31:0] PLL_MASK = 32'h0000_0F01;

  ////////////////////////////////////////////////////////////////////////////
  // sticky event bits, collision in bit 0
  typedef struct packed {
    logic fb_reset;   // feedback divider was reset by the sync line
    logic div_sync;   // clock divider was re-aligned
    logic two_away;   // fifo two slots from collision
    logic one_away;   // fifo one slot from collision
    logic collision;  // read met empty or write met full
  } alarm_t;

  // decoded configuration fields
  typedef struct packed {
    logic divsync_en;
    logic [2:0] offset;
    logic [1:0] div_m1;
    logic divsrc_sync;
    logic dual_mode;
    logic pll_en;
    logic fbrst_en;
    logic [3:0] fb_m1;
  } cfg_t;

  // pointer bring-up progress
  typedef enum {PTR_WAIT_WR, PTR_WAIT_RD, PTR_RUN} ptr_state_t;

endpackage

// ===== edge_sampler.sv
// two-flop resampler with rising-edge detect for one sync level
`timescale 1ns/10ps
module edge_sampler (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic level_i,
  output logic level_o,
  output logic rise_o
);

  logic meta_reg;   // first stage, read only by the second
  logic safe_reg;   // settled copy of the input
  logic last_reg;   // previous settled value
  logic meta_next;
  logic safe_next;
  logic last_next;

  ////////////////////////////////////////////////////////////////////////////
  // shift the level along the chain
  always_comb begin
    meta_next = level_i;
    safe_next = meta_reg;
    last_next = safe_reg;
  end

  // chain flops, frozen while the clock enable is low
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= 1'b0;
      safe_reg <= 1'b0;
      last_reg <= 1'b0;
    end else if (ce_i) begin
      meta_reg <= meta_next;
      safe_reg <= safe_next;
      last_reg <= last_next;
    end
  end

  // edge seen only on settled stages, never on the first one
  assign level_o = safe_reg;
  assign rise_o = safe_reg & ~last_reg;

endmodule

// ===== baseband_model.sv
// partner model: baseband source of samples, frame, strobe and sync lines
`timescale 1ns/10ps
module baseband_model (
  input wire logic clk_i,
  output logic frame_o,
  output logic strobe_o,
  output logic sync_o,
  output logic [15:0] sample_o,
  output logic sample_valid_o
);
  logic run = 1'b0; // stream on
  logic phase = 1'b0; // push every second cycle, matching the read rate
  logic [15:0] word = 16'h0000; // next word to send
  initial begin
    {sync_o, strobe_o, frame_o} = 3'h0;
    sample_o = 16'h0000;
    sample_valid_o = 1'b0;
  end
  // one-cycle pulses launched just after an edge, sampled a period later
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_i);
    {sync_o, strobe_o, frame_o} <= m;
    @(posedge clk_i);
    {sync_o, strobe_o, frame_o} <= 3'h0;
  endtask
  // called off the clock edge so the first push never races it
  task automatic start(input logic [15:0] b);
    word = b;
    run = 1'b1;
  endtask
  // idle cycles invert the previous output, so a stopped stream alternates the last word and its inverse
  always @(posedge clk_i) begin
    phase <= run & ~phase;
    sample_valid_o <= run & ~phase;
    if (run && !phase) begin
      sample_o <= word;
      word <= word + 16'h0001;
    end else begin
      sample_o <= ~sample_o;
    end
  end
endmodule

// ===== testbench.sv
// self-checking bench for the sync control block
`timescale 1ns/10ps
module testbench;
  logic clk_i, rst_b_i, ce_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic strobe, sync, frame, svalid, share_valid_o, alarm_o, irq_o;
  logic [15:0] sample, pos, neg;
  logic [15:0] ps_q[$], ng_q[$]; // shares seen, in order
  int error_cnt = 0;
  int checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  sync_control dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .output_strobe_i(strobe), .sync_i(sync),
    .frame_i(frame), .sample_i(sample), .sample_valid_i(svalid),
    .positive_share_o(pos), .negative_share_o(neg),
    .share_valid_o(share_valid_o), .alarm_o(alarm_o), .irq_o(irq_o));
  baseband_model bb_u (.clk_i(clk_i), .frame_o(frame), .strobe_o(strobe),
    .sync_o(sync), .sample_o(sample), .sample_valid_o(svalid));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // share valid stands one cycle, so catch it at every edge
  always @(posedge clk_i) begin
    if (share_valid_o === 1'b1) begin
      ps_q.push_back(pos);
      ng_q.push_back(neg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one single transfer; waits on hready, no assumed latency
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    hsize_i <= 3'h2;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hsize_i <= 3'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic rdchk(input logic [31:0] a, m, e);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd & m, e);
    chk({31'h0, hresp_o}, 32'h0);
  endtask
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask
  // frame (and strobe in dual mode), then a stream that must come out whole
  task automatic stream(input logic [15:0] b, input logic dual);
    int idx;
    logic [15:0] e;
    idx = -1;
    ps_q.delete();
    ng_q.delete();
    bb_u.pulse(3'h1);
    if (dual) bb_u.pulse(3'h2);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    bb_u.start(b);
    repeat (30) @(posedge clk_i);
    if (!dual) bb_u.pulse(3'h2);
    repeat (40) @(posedge clk_i);
    foreach (ps_q[i]) if (ps_q[i] === b && idx < 0) idx = i;
    chk({31'h0, idx >= 0 && idx + 12 <= ps_q.size()}, 32'h1);
    for (int j = 0; j < 12 && idx >= 0 && idx + j < ps_q.size(); j++) begin
      e = b + 16'(j);
      chk({16'h0, ps_q[idx + j]}, {16'h0, e});
      chk({16'h0, ng_q[idx + j]}, 32'h0000_FFFF - e);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {ce_i, rst_b_i, hsel_i, hwrite_i} = 4'h8;
    htrans_i = 2'h0;
    hsize_i = 3'h0;
    haddr_i = 32'h0;
    hwdata_i = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rdchk(sync_ctrl_pkg::OFS_MAIN, '1, sync_ctrl_pkg::MAIN_RST);
    rdchk(sync_ctrl_pkg::OFS_SYNC_SEL, '1, sync_ctrl_pkg::SEL_RST);
    rdchk(sync_ctrl_pkg::OFS_PLL, '1, sync_ctrl_pkg::PLL_RST);
    rdchk(sync_ctrl_pkg::OFS_ALARM, '1, 32'h0);
    rdchk(sync_ctrl_pkg::OFS_ENABLE, '1, 32'h0);
    ahb(1'b1, sync_ctrl_pkg::OFS_MAIN, '1);
    rdchk(sync_ctrl_pkg::OFS_MAIN, '1, sync_ctrl_pkg::MAIN_MASK);
    ahb(1'b1, sync_ctrl_pkg::OFS_MAIN, sync_ctrl_pkg::MAIN_RST);
    ahb(1'b1, sync_ctrl_pkg::OFS_ENABLE, 32'h8);
    // dual mode, pll bypassed, wraps through full scale and zero
    stream(16'hFFF8, 1'b1);
    rdchk(sync_ctrl_pkg::OFS_ALARM, 32'hF, 32'h8);
    chk({30'h0, alarm_o, irq_o}, 32'h1);
    ahb(1'b1, sync_ctrl_pkg::OFS_MAIN, 32'h140);
    ahb(1'b1, sync_ctrl_pkg::OFS_ENABLE, 32'h0);
    irqchk(1'b0);
    ahb(1'b1, sync_ctrl_pkg::OFS_ENABLE, 32'h8);
    irqchk(1'b1);
    ahb(1'b1, sync_ctrl_pkg::OFS_CLEAR, 32'h8);
    rdchk(sync_ctrl_pkg::OFS_ALARM, 32'h8, 32'h0);
    irqchk(1'b0);
    // starve the fifo while reads go on: collision must show
    @(negedge clk_i);
    bb_u.run = 1'b0;
    repeat (30) @(posedge clk_i);
    rdchk(sync_ctrl_pkg::OFS_ALARM, 32'h1, 32'h1);
    chk({31'h0, alarm_o}, 32'h1);
    ahb(1'b1, sync_ctrl_pkg::OFS_ENABLE, 32'h1);
    irqchk(1'b1);
    // clock enable low: bus stalls and sticky state holds
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, hreadyout_o}, 32'h0);
    chk({31'h0, alarm_o}, 32'h1);
    ce_i <= 1'b1;
    // pll mode: sync rise resets the feedback divider only when enabled
    ahb(1'b1, sync_ctrl_pkg::OFS_PLL, 32'h301);
    ahb(1'b1, sync_ctrl_pkg::OFS_SYNC_SEL, 32'h6);
    ahb(1'b1, sync_ctrl_pkg::OFS_MAIN, 32'h141);
    ahb(1'b1, sync_ctrl_pkg::OFS_CLEAR, 32'h1F);
    bb_u.pulse(3'h4);
    repeat (20) @(posedge clk_i);
    rdchk(sync_ctrl_pkg::OFS_ALARM, 32'h18, 32'h18);
    ahb(1'b1, sync_ctrl_pkg::OFS_PLL, 32'h300);
    ahb(1'b1, sync_ctrl_pkg::OFS_CLEAR, 32'h10);
    bb_u.pulse(3'h4);
    repeat (20) @(posedge clk_i);
    rdchk(sync_ctrl_pkg::OFS_ALARM, 32'h10, 32'h0);
    // single mode with pll: frame alone resets both pointers
    ahb(1'b1, sync_ctrl_pkg::OFS_SYNC_SEL, 32'h4);
    ahb(1'b1, sync_ctrl_pkg::OFS_MAIN, 32'h140);
    stream(16'h1230, 1'b0);
    ahb(1'b1, 32'h0000_0040, '1);
    rdchk(32'h0000_0040, '1, 32'h0);
    wrap_up();
  end
  // cut a hang short; the whole run needs well under this
  initial begin
    repeat (6000) @(posedge clk_i);
    error_cnt++;
    wrap_up();
  end
endmodule
